// ===== common/adc_port_pkg.sv
// Constants, carriers and lane mapping for the converter host port
`default_nettype none
package adc_port_pkg;
  // Clock period of i_clock
  localparam int CLK_NS = 40;
  // Shortest convert strobe, rounded up to whole cycles
  localparam int START_MIN_NS = 40;
  localparam int START_MIN_CYC = (START_MIN_NS + CLK_NS - 1) / CLK_NS;
  // Longest convert strobe, rounded down
  localparam int START_MAX_NS = 5400;
  localparam int START_MAX_CYC = START_MAX_NS / CLK_NS;
  // Recommended spacing of convert commands
  localparam int ACQ_NS = 10000;
  localparam int ACQ_CYC = (ACQ_NS + CLK_NS - 1) / CLK_NS;
  // Previous result stays readable this long after a start
  localparam int READ_VALID_NS = 16000;
  localparam int READ_VALID_CYC = READ_VALID_NS / CLK_NS;
  // Default conversion time, start to end of busy
  localparam int CONV_NS_DEF = 8000;
  // Result and lane widths
  localparam int RES_W = 12;
  localparam int LANE_W = 8;
  localparam int ZF_W = 4;
  // Reset value of the result register
  localparam logic [11:0] RESULT_RST = 12'h000;

  // Host control pins taken together
  typedef struct packed {
    logic select_n;
    logic read_convert;
    logic lane_swap;
  } pins_t;

  // The sixteen output pins: result pins then zero-fill pins
  typedef struct packed {
    logic [11:0] data;
    logic [3:0] zero;
  } bus_t;

  // Place a result on the sixteen pins, optionally lane swapped
  function automatic bus_t lane_map(input logic [11:0] res, input logic swap);
    logic [15:0] flat;
    flat = {res, 4'h0};
    if (swap) begin
      flat = {res[3:0], 4'h0, res[11:4]};
    end
    lane_map = bus_t'(flat);
  endfunction
endpackage
`default_nettype wire

// ===== design/conv_sequencer.sv
// Conversion sequencer: busy timing, sample hold and result register
`default_nettype none
module conv_sequencer #(
  parameter int CONV_CYC = 200
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_start,
  input wire logic [11:0] i_sample_code,
  output logic o_busy,
  output logic o_hold,
  output logic o_done,
  output logic [11:0] o_result
);
  import adc_port_pkg::*;

  // Cycle count inside a conversion
  logic [12:0] count_reg;
  // Code frozen at the moment of hold
  logic [11:0] held_reg;
  // Last cycle of the conversion
  logic last;

  assign last = o_busy && (count_reg == 13'(CONV_CYC - 1));

  // Busy and count; starts while busy are dropped
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_busy <= 1'b0;
      count_reg <= 13'h0000;
    end else if (!o_busy && i_start) begin
      o_busy <= 1'b1;
      count_reg <= 13'h0000;
    end else if (last) begin
      o_busy <= 1'b0;
    end else if (o_busy) begin
      count_reg <= count_reg + 13'h0001;
    end
  end

  // Sample and hold: freeze on start, track again at the end
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_hold <= 1'b0;
      held_reg <= RESULT_RST;
    end else if (!o_busy && i_start) begin
      o_hold <= 1'b1;
      held_reg <= i_sample_code;
    end else if (last) begin
      o_hold <= 1'b0;
    end
  end

  // Result updates only at the end, so the old one stays readable
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_result <= RESULT_RST;
      o_done <= 1'b0;
    end else begin
      o_done <= last;
      if (last) begin
        o_result <= held_reg;
      end
    end
  end
endmodule
`default_nettype wire

// ===== design/adc_host_port.sv
// Parallel host port of a 12-bit sampling converter
// Behaviour
// - Data pins float unless selected in read
// - Zero-fill pins drive only when selected reading
// - Unswapped: full word MSB first, zero-fill low
// - Swapped: lanes exchanged, low bits upper lane
// - Read/convert falling with select low starts
// - Read/convert rising with select low reads
// - Strobes ORed; select falling converts too
// - Select falling with read high reads
// - Busy low from start until result latched
// - Data valid when busy rises while reading
// - Result coded straight binary, MSB first
// - Convert commands during busy are ignored
// - Tracking resumes when conversion ends
// - Previous result readable early in conversion
`default_nettype none
module adc_host_port #(
  parameter int CONV_NS = adc_port_pkg::CONV_NS_DEF
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_select_n,
  input wire logic i_read_convert,
  input wire logic i_lane_swap,
  input wire logic [11:0] i_sample_code,
  output logic o_busy_n,
  output logic o_sample_hold,
  output logic [11:0] o_data_out,
  output logic o_data_oe_n,
  output logic [3:0] o_zero_fill_out,
  output logic o_zero_fill_oe_n
);
  import adc_port_pkg::*;

  // Conversion length in cycles, rounded up
  localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;

  // Control pins as one carrier
  pins_t pins;
  // Strobes ORed: low only when both are low
  logic strobe_n;
  // Output window: selected and in read
  logic read_en;
  // Sequencer state
  logic seq_busy;
  logic seq_hold;
  logic seq_done;
  logic [11:0] seq_result;
  // Pin image of the current result
  bus_t bus_next;

  assign pins = '{select_n: i_select_n, read_convert: i_read_convert,
                  lane_swap: i_lane_swap};

  // Level sensitive start, so a strobe still low at the end of
  // busy starts another conversion without acquisition
  assign strobe_n = pins.select_n | pins.read_convert;

  // Either edge order lands here: whichever strobe arrives last
  assign read_en = !pins.select_n && pins.read_convert;

  // Straight binary word placed on the lanes
  assign bus_next = lane_map(seq_result, pins.lane_swap);

  // Conversion timing and result storage
  conv_sequencer #(
    .CONV_CYC(CONV_CYC)
  ) u_seq (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_start(!strobe_n),
    .i_sample_code(i_sample_code),
    .o_busy(seq_busy),
    .o_hold(seq_hold),
    .o_done(seq_done),
    .o_result(seq_result)
  );

  // Output enables; high while floating
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_data_oe_n <= 1'b1;
      o_zero_fill_oe_n <= 1'b1;
    end else begin
      o_data_oe_n <= !read_en;
      o_zero_fill_oe_n <= !read_en;
    end
  end

  // Output data, registered from the same result as busy
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_data_out <= 12'h000;
      o_zero_fill_out <= 4'h0;
    end else begin
      o_data_out <= bus_next.data;
      o_zero_fill_out <= bus_next.zero;
    end
  end

  // Busy and hold pins; busy aligned with the data register
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_busy_n <= 1'b1;
      o_sample_hold <= 1'b0;
    end else begin
      o_busy_n <= !seq_busy;
      o_sample_hold <= seq_hold;
    end
  end

  // Helper for checks: length of the current busy low stretch
  logic [12:0] low_len_reg;
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      low_len_reg <= 13'h0000;
    end else if (!o_busy_n) begin
      low_len_reg <= low_len_reg + 13'h0001;
    end else begin
      low_len_reg <= 13'h0000;
    end
  end

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);

  // Floating whenever deselected or read/convert is low
  property p_hiz;
    (i_select_n || !i_read_convert) |=> (o_data_oe_n && o_zero_fill_oe_n);
  endproperty
  a_hiz: assert property (p_hiz) else $error("bus not floating");

  // Driven whenever selected in read
  property p_drive;
    (!i_select_n && i_read_convert) |=> (!o_data_oe_n && !o_zero_fill_oe_n);
  endproperty
  a_drive: assert property (p_drive) else $error("bus not driven");

  // Unswapped word layout
  property p_full;
    !i_lane_swap |=> (o_data_out == $past(seq_result)) && (o_zero_fill_out == 4'h0);
  endproperty
  a_full: assert property (p_full) else $error("full word wrong");

  // Swapped lane layout
  property p_swap;
    i_lane_swap |=> (o_data_out[11:8] == $past(seq_result[3:0]))
      && (o_data_out[7:4] == 4'h0)
      && ({o_data_out[3:0], o_zero_fill_out} == $past(seq_result[11:4]));
  endproperty
  a_swap: assert property (p_swap) else $error("swapped lanes wrong");

  // Accepted start shows on busy two edges later
  property p_start;
    (!i_select_n && !i_read_convert && !seq_busy) |=> seq_busy ##1 !o_busy_n;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");

  // Every busy stretch is exactly the conversion length
  property p_len;
    $rose(o_busy_n) |-> (low_len_reg == 13'(CONV_CYC));
  endproperty
  a_len: assert property (p_len) else $error("busy length wrong");

  // Data from the new result is on the pins as busy rises
  property p_valid;
    ($rose(o_busy_n) && !o_data_oe_n && !$past(i_lane_swap))
      |-> (o_data_out == seq_result);
  endproperty
  a_valid: assert property (p_valid) else $error("data late at busy rise");

  // Tracking again once busy has risen
  property p_track;
    $rose(o_busy_n) |-> !o_sample_hold;
  endproperty
  a_track: assert property (p_track) else $error("still holding");

  // Old result unchanged until the conversion ends
  property p_keep;
    seq_busy |=> ($stable(seq_result) || (!seq_busy && $past(seq_done) == 1'b0));
  endproperty
  a_keep: assert property (p_keep) else $error("result changed early");

  // Start puts the sample into hold
  property p_hold;
    (!strobe_n && !seq_busy) |=> ##1 o_sample_hold;
  endproperty
  a_hold: assert property (p_hold) else $error("hold missing");

  // Strobes still low as busy ends: a new conversion, no acquisition
  property p_restart;
    (seq_done && !strobe_n) |=> seq_busy;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart");

  // Main scenarios
  property p_c_read_at_end;
    $rose(o_busy_n) && !o_data_oe_n;
  endproperty
  c_read_at_end: cover property (p_c_read_at_end);

  property p_c_swap_read;
    !o_data_oe_n && $past(i_lane_swap);
  endproperty
  c_swap_read: cover property (p_c_swap_read);

  property p_c_restart;
    $rose(o_busy_n) ##1 $fell(o_busy_n);
  endproperty
  c_restart: cover property (p_c_restart);

  // Convert command arriving while busy, to be dropped
  property p_c_ignored;
    seq_busy && !strobe_n && !o_busy_n;
  endproperty
  c_ignored: cover property (p_c_ignored);

  // Start made by select falling last
  property p_c_sel_start;
    $fell(i_select_n) && !i_read_convert && !seq_busy;
  endproperty
  c_sel_start: cover property (p_c_sel_start);
endmodule
`default_nettype wire

// ===== tb/host_model.sv
// Host processor model driving the converter strobes
`default_nettype none
module host_model (
  input wire logic i_clock,
  output var adc_port_pkg::pins_t o_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  import adc_port_pkg::*;

  // Idle: deselected, read level
  initial o_pins = '{1'b1, 1'b1, 1'b0};

  // Strobes move only at the falling edge, clear of sampling
  task automatic drive(input logic sel_n, input logic rc, input logic swap);
    @(negedge i_clock);
    o_pins <= '{sel_n, rc, swap};
  endtask

  // Convert command; by_sel lets select fall last
  task automatic start(input bit by_sel, input logic swap);
    if (by_sel) begin
      drive(1'b1, 1'b0, swap);
    end
    drive(1'b0, 1'b0, swap);
    drive(1'b0, 1'b1, swap);
  endtask

  // Acquisition gap between commands
  task automatic settle();
    repeat (ACQ_CYC) @(negedge i_clock);
  endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the converter host port
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_port_pkg::*;
  // Short conversion keeps the run brief
  localparam int CNS = 400;
  localparam int CCYC = (CNS + CLK_NS - 1) / CLK_NS;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic [11:0] sample = 12'h000;
  pins_t pins;
  logic busy_n, hold, doe_n, zoe_n;
  logic [11:0] dout;
  logic [3:0] zout;
  int mismatches = 0;
  int n_compared = 0;
  bit [31:0] seed = 23;
  int q[$];
  int prev = 0;

  always #20 i_clock = ~i_clock;

  host_model host_model_i (.i_clock(i_clock), .o_pins(pins));
  adc_host_port #(.CONV_NS(CNS)) adc_host_port_i (
    .i_clock(i_clock), .i_reset(i_reset), .i_select_n(pins.select_n),
    .i_read_convert(pins.read_convert), .i_lane_swap(pins.lane_swap),
    .i_sample_code(sample), .o_busy_n(busy_n), .o_sample_hold(hold),
    .o_data_out(dout), .o_data_oe_n(doe_n), .o_zero_fill_out(zout),
    .o_zero_fill_oe_n(zoe_n));

  // Pseudo random source, fixed start
  function automatic bit [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected sixteen pins: data then zero-fill
  function automatic logic [15:0] pins_of(input int r, input logic s);
    logic [11:0] v;
    v = r[11:0];
    return s ? {v[3:0], 4'h0, v[11:4]} : {v, 4'h0};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One conversion; stray adds a command while busy
  task automatic convert(input bit by_sel, input bit stray);
    bit [31:0] r;
    logic swap;
    int n;
    r = xorshift();
    swap = r[0];
    r = xorshift();
    @(negedge i_clock);
    sample <= r[11:0];
    host_model_i.start(by_sel, swap);
    q.push_back(int'(r[11:0]));
    // Code moves after capture, so a late capture shows
    sample <= ~r[11:0];
    n = 0;
    while (busy_n !== 1'b0 && n < 8) begin
      @(negedge i_clock);
      n++;
    end
    check(16'(n), 16'h1);
    n = 0;
    while (busy_n === 1'b0 && n < 4 * CCYC) begin
      check(16'(hold), 16'h1);
      if (stray && n == 4) check({doe_n, zoe_n}, 16'h3);
      if (n == 5) check({dout, zout}, pins_of(prev, swap));
      host_model_i.drive(1'b0, !(stray && n == 2), swap);
      n++;
    end
    check(16'(n), 16'(CCYC));
    check({hold, doe_n, zoe_n}, 16'h0);
    check({dout, zout}, pins_of(q[0], swap));
    prev = q.pop_front();
    // Other lane order on the same result
    host_model_i.drive(1'b0, 1'b1, !swap);
    @(negedge i_clock);
    check({dout, zout}, pins_of(prev, !swap));
    check(16'(busy_n), 16'h1);
  endtask

  // Strobes left low past busy: a second conversion follows at once
  task automatic restart();
    bit [31:0] r;
    int n;
    r = xorshift();
    @(negedge i_clock);
    // Code held steady, so both conversions take the same value
    sample <= r[11:0];
    host_model_i.drive(1'b0, 1'b0, 1'b0);
    n = 0;
    while (busy_n !== 1'b0 && n < 8) begin
      @(negedge i_clock);
      n++;
    end
    n = 0;
    while (busy_n === 1'b0 && n < 4 * CCYC) begin
      @(negedge i_clock);
      n++;
    end
    check(16'(n), 16'(CCYC));
    // Busy stands high for a single cycle before the next one
    n = 0;
    while (busy_n === 1'b1 && n < 8) begin
      @(negedge i_clock);
      n++;
    end
    check(16'(n), 16'h1);
    host_model_i.drive(1'b0, 1'b1, 1'b0);
    n = 0;
    while (busy_n === 1'b0 && n < 4 * CCYC) begin
      @(negedge i_clock);
      n++;
    end
    q.push_back(int'(r[11:0]));
    check({hold, doe_n, zoe_n}, 16'h0);
    check({dout, zout}, pins_of(q[0], 1'b0));
    prev = q.pop_front();
  endtask

  // Reset, conversions, then the strobe table
  initial begin
    logic [1:0] seq [3];
    seq = '{2'b10, 2'b11, 2'b01};
    repeat (10) @(negedge i_clock);
    check({busy_n, hold, doe_n, zoe_n}, 16'hb);
    i_reset <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      convert(i[0], i == 3);
      host_model_i.settle();
    end
    restart();
    host_model_i.settle();
    foreach (seq[k]) begin
      host_model_i.drive(seq[k][1], seq[k][0], 1'b0);
      @(negedge i_clock);
      check({doe_n, zoe_n}, seq[k] == 2'b01 ? 16'h0 : 16'h3);
      if (seq[k] == 2'b01) check({dout, zout}, pins_of(prev, 1'b0));
    end
    summarize();
  end

  // Hang guard, well past the expected run
  initial begin
    #(40 * 20000);
    mismatches++;
    summarize();
  end
endmodule
`default_nettype wire
